// File: pwm_pkg.sv
// constants, register map and timing figures of the rf pulse width modulator
// Operation
// [R1] pulse rate is accepted from 1000 Hz up to 19800 Hz
// [R2] each period the rf output is on for the duty fraction, off otherwise
// [R3] least duty percent is ceil(rate in Hz times 50 us divided by 10000)
// [R4] a duty giving an on pulse under 50 us is refused, old value kept; code tests only R3, so duty 99 at 19800 Hz gives 499 cycles, 49.9 us
// [R5] host keeps rate and duty within limits; rate changes are not rechecked
// [R6] set duty accepts 0 to 100 percent and answers okay
// [R7] duty 100 keeps rf on permanently, there is no separate enable
// [R8] set rate takes rate plus one reserved argument and answers okay
// [R9] host always writes zero into the reserved rate argument
// [R10] settings readback order: channel, rate, reserved, mode, four reserved, extra, duty
// [R11] reported trigger mode reads 1 for free running
// [R12] host ignores every reserved readback field
// [R13] when enabled, external gate input gates the internal source instead; the code drives rf from the gate input alone, ignoring the internal pulse
// [R14] amplifier mode: external gate input marks pulses for power sampling
// [R15] in source mode power is sampled only while the rf pulse is on
// [R16] host is advised to use rates between 1 and 2 kHz
// [R17] period and on time come from counters, new values apply at period end
`default_nettype none
package pwm_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned MIN_PULSE_US = 50;
  localparam int unsigned PCT_SCALE    = 10_000;
  localparam int unsigned RATE_MIN_HZ  = 1000;
  localparam int unsigned RATE_MAX_HZ  = 19800;
  localparam int unsigned DUTY_FULL    = 100;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam int unsigned RATE_RST      = 1000;
  localparam int unsigned DUTY_RST      = 50;
  localparam int unsigned PERIOD_RST    = CLK_HZ / RATE_RST;
  localparam int unsigned ON_RST        = PERIOD_RST * DUTY_RST / DUTY_FULL;
  localparam logic [7:0]  TRIG_FREE_RUN = 8'h01;
  localparam logic [7:0]  RSV_FILL      = 8'hff;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [5:0] OFS_CHANNEL = 6'h00;
  localparam logic [5:0] OFS_RATE    = 6'h04;
  localparam logic [5:0] OFS_RATE_RS = 6'h08;
  localparam logic [5:0] OFS_MODE    = 6'h0c;
  localparam logic [5:0] OFS_RSV0    = 6'h10;
  localparam logic [5:0] OFS_RSV3    = 6'h1c;
  localparam logic [5:0] OFS_EXTRA   = 6'h20;
  localparam logic [5:0] OFS_DUTY    = 6'h24;
  localparam logic [5:0] OFS_CTRL    = 6'h28;
  localparam logic [5:0] OFS_STATUS  = 6'h2c;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_SRC_GATE = 0;
  localparam int CTRL_AMP_GATE = 1;
  localparam int RATE_RSV_LSB  = 16;
  localparam int ST_RF_ON      = 0;
  localparam int ST_MEASURE    = 1;
  localparam int ST_DUTY_REJ   = 2;
  localparam int ST_RATE_REJ   = 3;
  localparam int ST_PENDING    = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// File: pulse_divider.sv
// iterative restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
  parameter int W = 32
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              done,
  output logic [W-1:0]      quotient
);

  logic [W-1:0]         rem_r;
  logic [$clog2(W+1)-1:0] cnt_r;
  logic [W:0]           remShift;

  assign remShift = {rem_r, quotient[W-1]};

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rem_r    <= '0;
      quotient <= '0;
      cnt_r    <= '0;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        rem_r    <= '0;
        quotient <= dividend;
        cnt_r    <= ($clog2(W+1))'(W);
      end
      else if (cnt_r != '0)
      begin
        // divisor of zero yields all ones, callers never pass it
        if (remShift >= {1'b0, divisor})
        begin
          rem_r    <= W'(remShift - {1'b0, divisor});
          quotient <= {quotient[W-2:0], 1'b1};
        end
        else
        begin
          rem_r    <= remShift[W-1:0];
          quotient <= {quotient[W-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 1'b1;
        done  <= (cnt_r == 1);
      end
    end
  end

endmodule
`default_nettype wire

// File: rf_pulse_width_modulator.sv
// rf pulse width modulator with axi4-lite register access
`timescale 1ns/1ps
`default_nettype none
module rf_pulse_width_modulator #(
  parameter int         CW      = 24,
  parameter logic [7:0] CHANNEL = 8'h01
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        externalGateInput,
  output logic             rfEnable,
  output logic             measureEnable
);

  if (CW < 15 || CW > 25)
  begin : g_bad_width
    $error("CW must lie between 15 and 25");
  end

  typedef enum {SEQ_IDLE, SEQ_PERIOD, SEQ_ON} seq_t;

  // ************************************************************
  // bus write channel
  // ************************************************************
  logic        awHeld_r, wHeld_r, awHeld_nxt, wHeld_nxt, bvalid_nxt;
  logic [5:0]  awAddr_r;
  logic [31:0] wData_r, wrWord, mask;
  logic [3:0]  wStrb_r;
  logic        wrDo;

  assign wrDo       = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign awHeld_nxt = wrDo ? 1'b0 : ((s_axi_awvalid && s_axi_awready) ? 1'b1 : awHeld_r);
  assign wHeld_nxt  = wrDo ? 1'b0 : ((s_axi_wvalid && s_axi_wready) ? 1'b1 : wHeld_r);
  assign bvalid_nxt = wrDo ? 1'b1 : (s_axi_bready ? 1'b0 : s_axi_bvalid);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= '0;
      wData_r       <= '0;
      wStrb_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        awAddr_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      awHeld_r      <= awHeld_nxt;
      wHeld_r       <= wHeld_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      // one write in flight: channels close until the response is taken
      s_axi_awready <= !awHeld_nxt && !bvalid_nxt;
      s_axi_wready  <= !wHeld_nxt && !bvalid_nxt;
    end
  end

  // ************************************************************
  // settings registers
  // ************************************************************
  logic [14:0] rate_r;
  logic [15:0] rateRsv_r;
  logic [6:0]  dutyReq_r;
  logic        srcGate_r, ampGate_r, dutyRej_r, rateRej_r, calcReq_r;
  logic [31:0] curRate, curCtrl, curDuty;
  logic [31:0] newRate, newDuty;
  logic        rateOk, dutyOk, accepted, calcStart;

  genvar gb;
  for (gb = 0; gb < 4; gb++)
  begin : g_mask
    assign mask[gb*8 +: 8] = {8{wStrb_r[gb]}};
  end

  assign curRate = {rateRsv_r, 1'b0, rate_r};
  assign curDuty = {25'h0, dutyReq_r};
  assign curCtrl = {30'h0, ampGate_r, srcGate_r};
  assign wrWord  = wData_r & mask;
  assign newRate = (curRate & ~mask) | wrWord;
  assign newDuty = (curDuty & ~mask) | wrWord;
  assign rateOk  = newRate[15:0] >= 16'(pwm_pkg::RATE_MIN_HZ)
                && newRate[15:0] <= 16'(pwm_pkg::RATE_MAX_HZ);                // R1
  // duty*10000 >= rate*50 is the rounded-up least duty without a divider
  assign dutyOk  = newDuty <= pwm_pkg::DUTY_FULL
                && (newDuty == 0 || newDuty == pwm_pkg::DUTY_FULL
                 || newDuty * pwm_pkg::PCT_SCALE >= {17'h0, rate_r} * pwm_pkg::MIN_PULSE_US); // R3 R4
  assign accepted = wrDo && ((awAddr_r == pwm_pkg::OFS_RATE && rateOk)
                          || (awAddr_r == pwm_pkg::OFS_DUTY && dutyOk));

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rate_r      <= 15'(pwm_pkg::RATE_RST);
      rateRsv_r   <= '0;
      dutyReq_r   <= 7'(pwm_pkg::DUTY_RST);
      srcGate_r   <= 1'b0;
      ampGate_r   <= 1'b0;
      dutyRej_r   <= 1'b0;
      rateRej_r   <= 1'b0;
      s_axi_bresp <= pwm_pkg::RESP_OKAY;
    end
    else if (wrDo)
    begin
      s_axi_bresp <= pwm_pkg::RESP_OKAY;
      case (awAddr_r)
        pwm_pkg::OFS_RATE:
        begin
          rateRej_r <= !rateOk;
          if (rateOk)
          begin
            rate_r    <= newRate[14:0];                                      // R8
            rateRsv_r <= newRate[31:pwm_pkg::RATE_RSV_LSB];
          end
          else
            s_axi_bresp <= pwm_pkg::RESP_SLVERR;
        end
        pwm_pkg::OFS_DUTY:
        begin
          dutyRej_r <= !dutyOk;
          if (dutyOk)
            dutyReq_r <= newDuty[6:0];                                       // R6
          else
            s_axi_bresp <= pwm_pkg::RESP_SLVERR;                             // R4
        end
        pwm_pkg::OFS_CTRL:
        begin
          srcGate_r <= newRateCtrl(curCtrl, wrWord, mask, pwm_pkg::CTRL_SRC_GATE); // R13
          ampGate_r <= newRateCtrl(curCtrl, wrWord, mask, pwm_pkg::CTRL_AMP_GATE); // R14
        end
        default:
          s_axi_bresp <= pwm_pkg::RESP_SLVERR;
      endcase
    end
  end

  function automatic logic newRateCtrl(input logic [31:0] cur, input logic [31:0] wr,
                                       input logic [31:0] m, input int pos);
    newRateCtrl = m[pos] ? wr[pos] : cur[pos];
  endfunction

  // a setting that lands while a calculation starts is not lost
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      calcReq_r <= 1'b0;
    else if (accepted)
      calcReq_r <= 1'b1;
    else if (calcStart)
      calcReq_r <= 1'b0;
  end

  // ************************************************************
  // period and on-time calculation
  // ************************************************************
  seq_t        seq_r;
  logic        divStart_r, divDone;
  logic [31:0] divA_r, divB_r, divQ;
  logic [6:0]  dutySnap_r, dutyPend_r;
  logic [CW-1:0] periodPend_r, onPend_r;
  logic        pendValid_r;
  logic        wrap;

  assign calcStart = (seq_r == SEQ_IDLE) && calcReq_r;

  pulse_divider #(.W(32)) u_div (
    .clock    (clock),
    .rstn     (rstn),
    .start    (divStart_r),
    .dividend (divA_r),
    .divisor  (divB_r),
    .done     (divDone),
    .quotient (divQ)
  );

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      seq_r        <= SEQ_IDLE;
      divStart_r   <= 1'b0;
      divA_r       <= '0;
      divB_r       <= '0;
      dutySnap_r   <= '0;
      dutyPend_r   <= '0;
      periodPend_r <= '0;
      onPend_r     <= '0;
    end
    else
    begin
      divStart_r <= 1'b0;
      case (seq_r)
        SEQ_IDLE:
          if (calcReq_r)
          begin
            divA_r     <= pwm_pkg::CLK_HZ;
            divB_r     <= {17'h0, rate_r};
            dutySnap_r <= dutyReq_r;
            divStart_r <= 1'b1;
            seq_r      <= SEQ_PERIOD;
          end
        SEQ_PERIOD:
          if (divDone)
          begin
            periodPend_r <= divQ[CW-1:0];
            divA_r       <= 32'(divQ[CW-1:0] * dutySnap_r);                  // R2
            divB_r       <= pwm_pkg::DUTY_FULL;
            divStart_r   <= 1'b1;
            seq_r        <= SEQ_ON;
          end
        SEQ_ON:
          if (divDone)
          begin
            onPend_r   <= divQ[CW-1:0];
            dutyPend_r <= dutySnap_r;
            seq_r      <= SEQ_IDLE;
          end
        default:
          seq_r <= SEQ_IDLE;
      endcase
    end
  end

  // new results win over the load that consumes older ones; no load mid-calculation
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pendValid_r <= 1'b0;
    else if (seq_r == SEQ_ON && divDone)
      pendValid_r <= 1'b1;
    else if (wrap && seq_r == SEQ_IDLE)
      pendValid_r <= 1'b0;
  end

  // ************************************************************
  // period counter and rf gate
  // ************************************************************
  logic [CW-1:0] cnt_r, periodAct_r, onAct_r;
  logic [6:0]    dutyAct_r;
  logic          rfOn, gateSel;

  assign wrap    = cnt_r >= periodAct_r - 1'b1;
  assign rfOn    = (dutyAct_r == 7'(pwm_pkg::DUTY_FULL)) || (cnt_r < onAct_r); // R2 R7
  assign gateSel = srcGate_r || ampGate_r;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r       <= '0;
      periodAct_r <= CW'(pwm_pkg::PERIOD_RST);
      onAct_r     <= CW'(pwm_pkg::ON_RST);
      dutyAct_r   <= 7'(pwm_pkg::DUTY_RST);
    end
    else if (wrap)
    begin
      cnt_r <= '0;                                                          // R17
      // half-done calculation would pair a new period with an old on time
      if (pendValid_r && seq_r == SEQ_IDLE)
      begin
        periodAct_r <= periodPend_r;                                        // R17
        onAct_r     <= onPend_r;
        dutyAct_r   <= dutyPend_r;
      end
    end
    else
      cnt_r <= cnt_r + 1'b1;                                                // R17
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rfEnable      <= 1'b0;
      measureEnable <= 1'b0;
    end
    else
    begin
      rfEnable      <= srcGate_r ? externalGateInput : rfOn;                // R13
      // sampling window follows the internal pulse, or the external gate input when either gate mode is set
      measureEnable <= gateSel ? externalGateInput : rfOn;                  // R14 R15
    end
  end

  // ************************************************************
  // bus read channel
  // ************************************************************
  logic [31:0] rdMux;
  logic        rdOk;

  always_comb
  begin
    rdMux = '0;
    rdOk  = 1'b1;
    case (s_axi_araddr)
      pwm_pkg::OFS_CHANNEL: rdMux = {24'h0, CHANNEL};                       // R10
      pwm_pkg::OFS_RATE:    rdMux = {17'h0, rate_r};
      pwm_pkg::OFS_RATE_RS: rdMux = {16'h0, rateRsv_r};
      pwm_pkg::OFS_MODE:    rdMux = {24'h0, pwm_pkg::TRIG_FREE_RUN};        // R11
      pwm_pkg::OFS_EXTRA:   rdMux = '0;
      pwm_pkg::OFS_DUTY:    rdMux = {25'h0, dutyReq_r};
      pwm_pkg::OFS_CTRL:    rdMux = curCtrl;
      pwm_pkg::OFS_STATUS:
      begin
        rdMux[pwm_pkg::ST_RF_ON]    = rfEnable;
        rdMux[pwm_pkg::ST_MEASURE]  = measureEnable;
        rdMux[pwm_pkg::ST_DUTY_REJ] = dutyRej_r;
        rdMux[pwm_pkg::ST_RATE_REJ] = rateRej_r;
        rdMux[pwm_pkg::ST_PENDING]  = pendValid_r || calcReq_r || (seq_r != SEQ_IDLE);
      end
      default:
      begin
        if (s_axi_araddr >= pwm_pkg::OFS_RSV0 && s_axi_araddr <= pwm_pkg::OFS_RSV3
            && s_axi_araddr[1:0] == 2'h0)
          rdMux = {24'h0, pwm_pkg::RSV_FILL};
        else
          rdOk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= pwm_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid  <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= rdOk ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_RATE_RANGE: assert property (@(posedge clock) disable iff (!rstn)  // R1
    rate_r >= 15'(pwm_pkg::RATE_MIN_HZ) && rate_r <= 15'(pwm_pkg::RATE_MAX_HZ))
    else $error("pulse rate outside its range");

  AST_ON_WINDOW: assert property (@(posedge clock) disable iff (!rstn)  // R2
    (!srcGate_r && cnt_r < onAct_r) |=> rfEnable)
    else $error("rf off inside the on window");

  AST_OFF_WINDOW: assert property (@(posedge clock) disable iff (!rstn)  // R2
    (!srcGate_r && cnt_r >= onAct_r && dutyAct_r != 7'd100) |=> !rfEnable)
    else $error("rf on outside the on window");

  AST_MIN_PULSE: assert property (@(posedge clock) disable iff (!rstn)  // R4
    (wrDo && awAddr_r == pwm_pkg::OFS_DUTY && !dutyOk)
      |=> $stable(dutyReq_r) && s_axi_bvalid && s_axi_bresp == pwm_pkg::RESP_SLVERR)
    else $error("short duty was not refused");

  AST_DUTY_OK: assert property (@(posedge clock) disable iff (!rstn)  // R3
    (wrDo && awAddr_r == pwm_pkg::OFS_DUTY && dutyOk && newDuty != 0 && newDuty != 100)
      |=> 32'(dutyReq_r) * 10000 >= 32'(rate_r) * 50)
    else $error("accepted duty below least duty");

  AST_FULL_ON: assert property (@(posedge clock) disable iff (!rstn)  // R7
    (dutyAct_r == 7'd100 && !srcGate_r) |=> rfEnable)
    else $error("full duty did not hold rf on");

  AST_EXT_GATE: assert property (@(posedge clock) disable iff (!rstn)  // R13
    srcGate_r |=> rfEnable == $past(externalGateInput))
    else $error("rf does not follow external gate");

  AST_AMP_SAMPLE: assert property (@(posedge clock) disable iff (!rstn)  // R14
    ampGate_r |=> measureEnable == $past(externalGateInput))
    else $error("sampling does not follow external gate");

  AST_SAMPLE_IN_PULSE: assert property (@(posedge clock) disable iff (!rstn)  // R15
    (!$past(ampGate_r) && measureEnable) |-> rfEnable)
    else $error("sampling outside the rf pulse");

  AST_BOUNDARY: assert property (@(posedge clock) disable iff (!rstn)  // R17
    !$stable(periodAct_r) || !$stable(onAct_r) |-> $past(wrap) && cnt_r == 0)
    else $error("timing changed inside a period");

  AST_MODE_READ: assert property (@(posedge clock) disable iff (!rstn)  // R11
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == pwm_pkg::OFS_MODE)
      |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0001)
    else $error("trigger mode not free running");

  AST_RATE_ANSWER: assert property (@(posedge clock) disable iff (!rstn)  // R8
    (wrDo && awAddr_r == pwm_pkg::OFS_RATE && rateOk)
      |=> s_axi_bvalid && s_axi_bresp == pwm_pkg::RESP_OKAY ##0 calcReq_r [*1])
    else $error("rate write not answered okay");

endmodule
`default_nettype wire

// File: gate_source.sv
// model of the outside party driving the external gate input
`timescale 1ns/1ps
`default_nettype none
module gate_source #(
  parameter int HI = 7,
  parameter int LO = 5
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic enable,
  output logic      gate
);
  logic [7:0] phaseCnt_r;

  // ************************************************************
  // pulse train, uneven high and low so a fixed lag shows up
  // ************************************************************
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      phaseCnt_r <= 8'h00;
      gate       <= 1'b0;
    end
    else if (!enable)
    begin
      phaseCnt_r <= 8'h00;
      gate       <= 1'b0;
    end
    else if (phaseCnt_r == 8'(gate ? HI - 1 : LO - 1))
    begin
      phaseCnt_r <= 8'h00;
      gate       <= ~gate;
    end
    else
    begin
      phaseCnt_r <= phaseCnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking testbench for the rf pulse width modulator
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ************************************************************
  // signals
  // ************************************************************
  localparam logic [1:0] OK = pwm_pkg::RESP_OKAY;
  localparam logic [1:0] ER = pwm_pkg::RESP_SLVERR;
  localparam int         P  = pwm_pkg::CLK_HZ / pwm_pkg::RATE_MAX_HZ;
  logic        clock;
  logic        rstn;
  logic [5:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [5:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        gate;
  logic        gateOn;
  logic        rfEnable;
  logic        measureEnable;
  logic [31:0] rsvData;
  logic [1:0]  rsvResp;
  int          nFail;
  int          nTests;

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  rf_pulse_width_modulator dut (
    .clock(clock), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .externalGateInput(gate), .rfEnable(rfEnable), .measureEnable(measureEnable)
  );

  gate_source partner (.clock(clock), .rstn(rstn), .enable(gateOn), .gate(gate));

  // ************************************************************
  // bus and compare tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      nFail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    check({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask

  task automatic rawRd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rawRd(a, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, er});
  endtask

  // polls until new timing is computed and loaded at a period end
  task automatic settle;
    logic [31:0] s;
    logic [1:0]  r;
    int          i;
    i = 0;
    do
    begin
      rawRd(pwm_pkg::OFS_STATUS, s, r);
      i++;
    end while (s[pwm_pkg::ST_PENDING] !== 1'b0 && i < 5000);
    check(32'(s[pwm_pkg::ST_PENDING]), 32'h0);
    repeat (2) @(negedge clock);
  endtask

  task automatic measure(input int per, input int on);
    int   n;
    int   hi;
    int   bad;
    logic prev;
    n    = 0;
    hi   = 0;
    bad  = 0;
    prev = 1'b1;
    @(negedge clock);
    while (!(prev === 1'b0 && rfEnable === 1'b1) && n < 3 * per)
    begin
      prev = rfEnable;
      @(negedge clock);
      n++;
    end
    for (int i = 0; i < per; i++)
    begin
      if (rfEnable === 1'b1) hi++;
      if (measureEnable !== rfEnable) bad++;
      @(negedge clock);
    end
    check(32'(hi), 32'(on));
    check(32'(bad), 32'h0);
  endtask

  task automatic flat(input logic lvl, input int n);
    int bad;
    bad = 0;
    repeat (n)
    begin
      @(negedge clock);
      if (rfEnable !== lvl) bad++;
    end
    check(32'(bad), 32'h0);
  endtask

  task automatic gateChk(input logic rfToo);
    int   bad;
    logic pg;
    bad = 0;
    @(negedge clock);
    pg = gate;
    repeat (60)
    begin
      @(negedge clock);
      if (measureEnable !== pg || (rfToo && rfEnable !== pg)) bad++;
      pg = gate;
    end
    check(32'(bad), 32'h0);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial
  begin
    nFail = 0;
    nTests = 0;
    {rstn, awvalid, wvalid, bready, arvalid, rready, gateOn} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = 48'h0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rdc(pwm_pkg::OFS_CHANNEL, 32'h1, OK);
    rdc(pwm_pkg::OFS_RATE, 32'h3e8, OK);
    rdc(pwm_pkg::OFS_MODE, {24'h0, pwm_pkg::TRIG_FREE_RUN}, OK);
    rdc(pwm_pkg::OFS_DUTY, 32'h32, OK);
    rdc(6'h30, 32'h0, ER);
    measure(pwm_pkg::PERIOD_RST, pwm_pkg::ON_RST);
    $display("test reset done");
    wr(pwm_pkg::OFS_RATE, 32'h4e20, ER);
    wr(pwm_pkg::OFS_RATE, 32'h3e7, ER);
    rdc(pwm_pkg::OFS_RATE, 32'h3e8, OK);
    wr(pwm_pkg::OFS_RATE, 32'h4d58, OK);
    rdc(pwm_pkg::OFS_RATE, 32'h4d58, OK);
    rawRd(pwm_pkg::OFS_RSV0, rsvData, rsvResp);
    check({30'h0, rsvResp}, {30'h0, OK});
    $display("test rate done");
    wr(pwm_pkg::OFS_DUTY, 32'h62, ER);
    rdc(pwm_pkg::OFS_DUTY, 32'h32, OK);
    wr(pwm_pkg::OFS_DUTY, 32'h65, ER);
    wr(pwm_pkg::OFS_DUTY, 32'h63, OK);
    settle;
    measure(P, P * 99 / 100);
    wr(pwm_pkg::OFS_DUTY, 32'h64, OK);
    settle;
    flat(1'b1, 2 * P);
    wr(pwm_pkg::OFS_DUTY, 32'h0, OK);
    settle;
    flat(1'b0, 2 * P);
    wr(pwm_pkg::OFS_DUTY, 32'h32, ER);
    wr(pwm_pkg::OFS_RATE, 32'h3e8, OK);
    wr(pwm_pkg::OFS_DUTY, 32'h32, OK);
    settle;
    measure(pwm_pkg::PERIOD_RST, pwm_pkg::ON_RST);
    $display("test duty done");
    @(posedge clock);
    gateOn <= 1'b1;
    wr(pwm_pkg::OFS_CTRL, 32'h1, OK);
    repeat (4) @(negedge clock);
    gateChk(1'b1);
    wr(pwm_pkg::OFS_CTRL, 32'h2, OK);
    repeat (4) @(negedge clock);
    gateChk(1'b0);
    rdc(pwm_pkg::OFS_CTRL, 32'h2, OK);
    $display("test gate done");
    conclude;
  end

  // cut a hang well beyond the longest expected run
  initial
  begin
    repeat (90000) @(posedge clock);
    nFail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    conclude;
  end
endmodule
`default_nettype wire
